// ---- hw/rcd_pkg.sv ----
package rcd_pkg;

	// ---------------------------------------------------------------
	// widths of the re-driven groups
	// ---------------------------------------------------------------
	localparam int ADDR_W = 16;
	localparam int BANK_W = 3;
	localparam int CMD_W = 3;
	localparam int TERM_W = 2;
	localparam int CKE_W = 2;
	localparam int SEL_W = 4;
	localparam int KIND_W = 2;

	// ---------------------------------------------------------------
	// fifo sizing
	// ---------------------------------------------------------------
	localparam int FIFO_DEPTH = 16;
	localparam int ENTRY_W = KIND_W + ADDR_W + BANK_W + CMD_W + TERM_W + CKE_W + SEL_W;

	// ---------------------------------------------------------------
	// field positions inside one queued entry
	// ---------------------------------------------------------------
	localparam int POS_SEL = 0;
	localparam int POS_CKE = POS_SEL + SEL_W;
	localparam int POS_TERM = POS_CKE + CKE_W;
	localparam int POS_CMD = POS_TERM + TERM_W;
	localparam int POS_BANK = POS_CMD + CMD_W;
	localparam int POS_ADDR = POS_BANK + BANK_W;
	localparam int POS_KIND = POS_ADDR + ADDR_W;

	// ---------------------------------------------------------------
	// entry kinds
	// ---------------------------------------------------------------
	localparam logic [1:0] KIND_ACCESS = 2'h0;
	localparam logic [1:0] KIND_CTRL_WORD = 2'h1;
	localparam logic [1:0] KIND_DESELECT = 2'h2;

	// ---------------------------------------------------------------
	// reset and idle values
	// ---------------------------------------------------------------
	localparam logic [SEL_W-1:0] SEL_ALL_HIGH = 4'hf;
	localparam logic [SEL_W-1:0] SEL_RESET = 4'h0;
	localparam logic [ADDR_W-1:0] ADDR_RESET = 16'h0000;
	localparam logic [BANK_W-1:0] BANK_RESET = 3'h0;
	localparam logic [CMD_W-1:0] CMD_RESET = 3'h0;
	localparam logic [TERM_W-1:0] TERM_RESET = 2'h0;
	localparam logic [CKE_W-1:0] CKE_RESET = 2'h0;

	// ---------------------------------------------------------------
	// pin synchroniser depth
	// ---------------------------------------------------------------
	localparam int SYNC_STAGES = 2;

endpackage

// ---- hw/rcd_fifo.sv ----
`timescale 1ns/1ps
module rcd_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 16
) (
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic arst_n_i,
	// filling side
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	// draining side
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0] count;
	logic [AW-1:0] next_wr_ptr;
	logic [AW-1:0] next_rd_ptr;
	logic [AW:0] next_count;
	logic [WIDTH-1:0] next_out_data;
	logic next_out_valid;
	logic push;
	logic pop;
	logic head_load;

	// the head word sits in out_data_o; count covers the array only
	assign in_ready_o = (count != DEPTH[AW:0]);
	assign push = in_valid_i && in_ready_o;
	assign pop = out_valid_o && out_ready_i;
	assign head_load = (!out_valid_o || pop) && (count != '0);

	// ---------------------------------------------------------------
	// pointer and head register next values
	// ---------------------------------------------------------------
	always_comb begin
		next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
		next_rd_ptr = head_load ? rd_ptr + 1'b1 : rd_ptr;
		next_count = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, head_load};
		next_out_data = head_load ? mem[rd_ptr] : out_data_o;
		next_out_valid = head_load || (out_valid_o && !pop);
	end

	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
			out_data_o <= '0;
			out_valid_o <= 1'b0;
		end else begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			count <= next_count;
			out_data_o <= next_out_data;
			out_valid_o <= next_out_valid;
		end
	end

	// storage array has no reset, so it maps onto plain ram
	always_ff @(posedge sys_clk_i) begin
		if (push) begin
			mem[wr_ptr] <= in_data_i;
		end
	end

endmodule // rcd_fifo

// ---- hw/rcd_top.sv ----
`timescale 1ns/1ps
module rcd_top #(
	parameter int FIFO_DEPTH = rcd_pkg::FIFO_DEPTH
) (
	// system clock and reset
	input wire logic sys_clk_i,
	input wire logic arst_n_i,
	// differential clock pins from the controller
	input wire logic ck_t_i,
	input wire logic ck_c_i,
	// gated inputs
	input wire logic [rcd_pkg::ADDR_W-1:0] addr_in_i,
	input wire logic [rcd_pkg::BANK_W-1:0] bank_addr_in_i,
	input wire logic row_strobe_in_n_i,
	input wire logic col_strobe_in_n_i,
	input wire logic write_en_in_n_i,
	// ungated inputs
	input wire logic [rcd_pkg::TERM_W-1:0] term_in_i,
	input wire logic [rcd_pkg::CKE_W-1:0] clk_en_in_i,
	// select inputs, bit 0 is select_in_zero, bit 1 select_in_one
	input wire logic [rcd_pkg::SEL_W-1:0] select_in_quad_n_i,
	// configuration pins
	input wire logic quad_select_enable_n_i,
	input wire logic addr_float_bit_i,
	input wire logic three_cycle_timing_i,
	input wire logic copy_a_en_i,
	input wire logic copy_b_en_i,
	// drain stall and queue status
	input wire logic drive_stall_i,
	output logic cmd_ready_o,
	output logic illegal_sel_o,
	// gated outputs, shared data with per-copy enables
	output logic [rcd_pkg::ADDR_W-1:0] gated_out_addr_o,
	output logic [rcd_pkg::BANK_W-1:0] gated_out_bank_o,
	output logic [rcd_pkg::CMD_W-1:0] gated_out_cmd_n_o,
	output logic gated_out_a_oe_o,
	output logic gated_out_b_oe_o,
	// select outputs
	output logic [1:0] select_out_zero_copies_n_o,
	output logic [1:0] select_out_one_copies_n_o,
	output logic [rcd_pkg::SEL_W-1:0] select_out_quad_n_o,
	output logic select_out_a_oe_o,
	output logic select_out_b_oe_o,
	// termination and clock enable outputs
	output logic [rcd_pkg::TERM_W-1:0] term_out_o,
	output logic term_out_a_oe_o,
	output logic term_out_b_oe_o,
	output logic [rcd_pkg::CKE_W-1:0] clk_en_out_o,
	output logic clk_en_out_a_oe_o,
	output logic clk_en_out_b_oe_o
);

	// ---------------------------------------------------------------
	// pin synchronisers
	// ---------------------------------------------------------------
	localparam int PIN_W = 2 + rcd_pkg::ADDR_W + rcd_pkg::BANK_W + rcd_pkg::CMD_W
		+ rcd_pkg::TERM_W + rcd_pkg::CKE_W + rcd_pkg::SEL_W + 5;

	logic [PIN_W-1:0] pin_raw;
	logic [PIN_W-1:0] pin_meta;
	logic [PIN_W-1:0] pin_sync;

	assign pin_raw = {ck_t_i, ck_c_i, addr_in_i, bank_addr_in_i, row_strobe_in_n_i,
		col_strobe_in_n_i, write_en_in_n_i, term_in_i, clk_en_in_i, select_in_quad_n_i,
		quad_select_enable_n_i, addr_float_bit_i, three_cycle_timing_i, copy_a_en_i,
		copy_b_en_i};

	// pin_meta is read only by pin_sync; nothing else looks at it
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			pin_meta <= '0;
			pin_sync <= '0;
		end else begin
			pin_meta <= pin_raw;
			pin_sync <= pin_meta;
		end
	end

	logic s_ck_t;
	logic s_ck_c;
	logic [rcd_pkg::ADDR_W-1:0] s_addr;
	logic [rcd_pkg::BANK_W-1:0] s_bank;
	logic [rcd_pkg::CMD_W-1:0] s_cmd;
	logic [rcd_pkg::TERM_W-1:0] s_term;
	logic [rcd_pkg::CKE_W-1:0] s_cke;
	logic [rcd_pkg::SEL_W-1:0] s_sel;
	logic s_quad_n;
	logic s_float;
	logic s_three;
	logic s_copy_a;
	logic s_copy_b;

	assign {s_ck_t, s_ck_c, s_addr, s_bank, s_cmd, s_term, s_cke, s_sel, s_quad_n, s_float,
		s_three, s_copy_a, s_copy_b} = pin_sync;

	// ---------------------------------------------------------------
	// crossing detector
	// ---------------------------------------------------------------
	logic ck_t_prev;
	logic ck_c_prev;
	logic next_ck_t_prev;
	logic next_ck_c_prev;
	logic crossing;
	logic clk_stopped;

	// a crossing is true rising while complement falls
	assign crossing = s_ck_t && !ck_t_prev && !s_ck_c && ck_c_prev;
	assign clk_stopped = !s_ck_t && !s_ck_c;

	always_comb begin
		next_ck_t_prev = s_ck_t;
		next_ck_c_prev = s_ck_c;
	end

	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ck_t_prev <= 1'b0;
			ck_c_prev <= 1'b0;
		end else begin
			ck_t_prev <= next_ck_t_prev;
			ck_c_prev <= next_ck_c_prev;
		end
	end

	// ---------------------------------------------------------------
	// select decode
	// ---------------------------------------------------------------
	logic [rcd_pkg::SEL_W-1:0] sel_eff;
	logic [2:0] low_count;
	logic pair_lo_both;
	logic pair_hi_both;
	logic sel_illegal;
	logic [1:0] kind;

	// two-select mode treats the upper selects as high
	assign sel_eff = s_quad_n ? {2'b11, s_sel[1:0]} : s_sel;
	assign pair_lo_both = !sel_eff[0] && !sel_eff[1];
	assign pair_hi_both = !sel_eff[2] && !sel_eff[3];
	assign low_count = 3'({2'b00, !sel_eff[0]} + {2'b00, !sel_eff[1]}
		+ {2'b00, !sel_eff[2]} + {2'b00, !sel_eff[3]});
	// three lows are never expected; they are dropped and flagged
	assign sel_illegal = (low_count == 3'h3);

	always_comb begin
		if (low_count == 3'h0) begin
			kind = rcd_pkg::KIND_DESELECT;
		end else if (pair_lo_both || pair_hi_both) begin
			kind = rcd_pkg::KIND_CTRL_WORD;
		end else begin
			kind = rcd_pkg::KIND_ACCESS;
		end
	end

	// ---------------------------------------------------------------
	// command queue
	// ---------------------------------------------------------------
	logic [rcd_pkg::ENTRY_W-1:0] entry_in;
	logic [rcd_pkg::ENTRY_W-1:0] entry_out;
	logic entry_in_valid;
	logic entry_out_valid;
	logic entry_pop_ready;
	logic queue_ready;

	// sampled once per crossing, all groups in one word
	assign entry_in = {kind, s_addr, s_bank, s_cmd, s_term, s_cke, sel_eff};
	assign entry_in_valid = crossing && !sel_illegal;
	assign entry_pop_ready = !drive_stall_i;
	assign cmd_ready_o = queue_ready;

	rcd_fifo #(
		.WIDTH(rcd_pkg::ENTRY_W),
		.DEPTH(FIFO_DEPTH)
	) u_queue (
		.sys_clk_i(sys_clk_i),
		.arst_n_i(arst_n_i),
		.in_valid_i(entry_in_valid),
		.in_ready_o(queue_ready),
		.in_data_i(entry_in),
		.out_valid_o(entry_out_valid),
		.out_ready_i(entry_pop_ready),
		.out_data_o(entry_out)
	);

	logic [1:0] q_kind;
	logic [rcd_pkg::ADDR_W-1:0] q_addr;
	logic [rcd_pkg::BANK_W-1:0] q_bank;
	logic [rcd_pkg::CMD_W-1:0] q_cmd;
	logic [rcd_pkg::TERM_W-1:0] q_term;
	logic [rcd_pkg::CKE_W-1:0] q_cke;
	logic [rcd_pkg::SEL_W-1:0] q_sel;
	logic apply;

	assign q_kind = entry_out[rcd_pkg::POS_KIND +: rcd_pkg::KIND_W];
	assign q_addr = entry_out[rcd_pkg::POS_ADDR +: rcd_pkg::ADDR_W];
	assign q_bank = entry_out[rcd_pkg::POS_BANK +: rcd_pkg::BANK_W];
	assign q_cmd = entry_out[rcd_pkg::POS_CMD +: rcd_pkg::CMD_W];
	assign q_term = entry_out[rcd_pkg::POS_TERM +: rcd_pkg::TERM_W];
	assign q_cke = entry_out[rcd_pkg::POS_CKE +: rcd_pkg::CKE_W];
	assign q_sel = entry_out[rcd_pkg::POS_SEL +: rcd_pkg::SEL_W];
	assign apply = entry_out_valid && entry_pop_ready;

	// ---------------------------------------------------------------
	// output state
	// ---------------------------------------------------------------
	logic [rcd_pkg::ADDR_W-1:0] next_addr;
	logic [rcd_pkg::BANK_W-1:0] next_bank;
	logic [rcd_pkg::CMD_W-1:0] next_cmd;
	logic [rcd_pkg::TERM_W-1:0] next_term;
	logic [rcd_pkg::CKE_W-1:0] next_cke;
	logic [rcd_pkg::SEL_W-1:0] sel_q;
	logic [rcd_pkg::SEL_W-1:0] next_sel;
	logic drive_en;
	logic next_drive_en;
	logic addr_floated;
	logic next_addr_floated;
	logic three_latched;
	logic next_three_latched;
	logic next_illegal;

	// output registers change on a popped crossing word; clock enables also clear on a stopped clock pair
	always_comb begin
		next_addr = gated_out_addr_o;
		next_bank = gated_out_bank_o;
		next_cmd = gated_out_cmd_n_o;
		next_term = term_out_o;
		next_cke = clk_en_out_o;
		next_sel = sel_q;
		// first crossing after release turns the drivers on
		next_drive_en = drive_en || crossing;
		// three-cycle timing sticks until the next reset
		next_three_latched = three_latched || s_three;
		// a float left over from before three-cycle timing is dropped at once
		next_addr_floated = addr_floated && !next_three_latched;
		next_illegal = crossing && sel_illegal;
		if (apply) begin
			case (q_kind)
				rcd_pkg::KIND_ACCESS: begin
					next_addr = q_addr;
					next_bank = q_bank;
					next_cmd = q_cmd;
					next_term = q_term;
					next_cke = q_cke;
					next_sel = q_sel;
					next_addr_floated = 1'b0;
				end
				rcd_pkg::KIND_CTRL_WORD: begin
					next_sel = rcd_pkg::SEL_ALL_HIGH;
				end
				rcd_pkg::KIND_DESELECT: begin
					next_sel = rcd_pkg::SEL_ALL_HIGH;
					next_term = q_term;
					next_cke = q_cke;
					// float only with the bit set and three-cycle timing off
					next_addr_floated = s_float && !next_three_latched;
				end
				default: begin
					next_sel = sel_q;
				end
			endcase
		end
		// stopped clock pair pulls clock enables low; the next access or deselect word restores them
		if (clk_stopped) begin
			next_cke = rcd_pkg::CKE_RESET;
		end
	end

	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			gated_out_addr_o <= rcd_pkg::ADDR_RESET;
			gated_out_bank_o <= rcd_pkg::BANK_RESET;
			gated_out_cmd_n_o <= rcd_pkg::CMD_RESET;
			term_out_o <= rcd_pkg::TERM_RESET;
			clk_en_out_o <= rcd_pkg::CKE_RESET;
			sel_q <= rcd_pkg::SEL_RESET;
			drive_en <= 1'b0;
			addr_floated <= 1'b0;
			three_latched <= 1'b0;
			illegal_sel_o <= 1'b0;
		end else begin
			gated_out_addr_o <= next_addr;
			gated_out_bank_o <= next_bank;
			gated_out_cmd_n_o <= next_cmd;
			term_out_o <= next_term;
			clk_en_out_o <= next_cke;
			sel_q <= next_sel;
			drive_en <= next_drive_en;
			addr_floated <= next_addr_floated;
			three_latched <= next_three_latched;
			illegal_sel_o <= next_illegal;
		end
	end

	// ---------------------------------------------------------------
	// select pin mapping
	// ---------------------------------------------------------------
	// two-select mode drives two copies of each select; quad pins mirror
	assign select_out_zero_copies_n_o = {2{sel_q[0]}};
	assign select_out_one_copies_n_o = {2{sel_q[1]}};
	assign select_out_quad_n_o = sel_q;

	// ---------------------------------------------------------------
	// output enables
	// ---------------------------------------------------------------
	logic pins_live;
	logic cke_forced_low;

	// a stopped clock pair floats the bus; only the clock enable register is cleared
	assign pins_live = drive_en && !clk_stopped && arst_n_i;
	assign cke_forced_low = !pins_live;

	assign gated_out_a_oe_o = pins_live && s_copy_a && !addr_floated;
	assign gated_out_b_oe_o = pins_live && s_copy_b && !addr_floated;
	assign select_out_a_oe_o = pins_live && s_copy_a;
	assign select_out_b_oe_o = pins_live && s_copy_b;
	assign term_out_a_oe_o = pins_live && s_copy_a;
	assign term_out_b_oe_o = pins_live && s_copy_b;
	// clock enables are driven whenever the rest floats, and read low except in the first cycle of a stop
	assign clk_en_out_a_oe_o = cke_forced_low || s_copy_a;
	assign clk_en_out_b_oe_o = cke_forced_low || s_copy_b;

endmodule // rcd_top

// ---- sim/rcd_ctl_model.sv ----
`timescale 1ns/1ps
// controller stand-in: runs the clock pair and holds each word for one whole period
module rcd_ctl_model (
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic arst_n_i,
	// request from the bench
	input wire logic run_i,
	input wire logic [31:0] word_i,
	// pins toward the block
	output logic ck_t_o,
	output logic ck_c_o,
	output logic [31:0] pins_o
);
	logic [1:0] phase;
	logic [1:0] next_phase;
	logic [31:0] held;
	logic [31:0] next_held;
	logic idle;
	// ---------------------------------------------------------------
	// clock pair and word latch
	// ---------------------------------------------------------------
	// a word is taken only at the rise so it stands a full period
	always_comb begin
		next_phase = run_i ? phase + 2'h1 : 2'h0;
		next_held = (run_i && phase == 2'h1) ? word_i : held;
	end
	// registers only
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			phase <= 2'h0;
			held <= 32'h0;
		end else begin
			phase <= next_phase;
			held <= next_held;
		end
	end
	// stopping is only ever both low, never a static complementary pair
	assign ck_t_o = run_i & phase[1];
	assign ck_c_o = run_i & ~phase[1];
	// unselected gated lines toggle so a leaky pass-through shows up
	assign idle = held[31] ? (held[27:26] == 2'h3) : (held[29:26] == 4'hf);
	assign pins_o = idle ? {held[31:22], ~held[21:0] ^ {22{phase[0]}}} : held;
endmodule // rcd_ctl_model

// ---- sim/rcd_top_props.sv ----
`timescale 1ns/1ps
module rcd_top_props #(
	parameter int FIFO_DEPTH = 16
) (
	input wire logic sys_clk_i,
	input wire logic arst_n_i,
	input wire logic ck_t_i,
	input wire logic ck_c_i,
	input wire logic copy_a_en_i,
	input wire logic copy_b_en_i,
	input wire logic three_cycle_timing_i,
	input wire logic drive_stall_i,
	input wire logic illegal_sel_o,
	input wire logic [rcd_pkg::ADDR_W-1:0] gated_out_addr_o,
	input wire logic gated_out_a_oe_o,
	input wire logic gated_out_b_oe_o,
	input wire logic [1:0] select_out_zero_copies_n_o,
	input wire logic [1:0] select_out_one_copies_n_o,
	input wire logic [rcd_pkg::SEL_W-1:0] select_out_quad_n_o,
	input wire logic select_out_a_oe_o,
	input wire logic select_out_b_oe_o,
	input wire logic term_out_a_oe_o,
	input wire logic [rcd_pkg::CKE_W-1:0] clk_en_out_o,
	input wire logic clk_en_out_a_oe_o,
	input wire logic clk_en_out_b_oe_o
);
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!arst_n_i);
	// ---------------------------------------------------------------
	// multi-step conditions
	// ---------------------------------------------------------------
	sequence s_clock_stopped;
		(!ck_t_i && !ck_c_i) [*4];
	endsequence
	sequence s_stalled;
		drive_stall_i [*5];
	endsequence
	// pins are synchronised, so the figures allow for two cycles of lag
	sequence s_pinned_drive;
		(three_cycle_timing_i && copy_a_en_i && (ck_t_i || ck_c_i)) [*5];
	endsequence
	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	chk_release_float: assert property ($rose(arst_n_i) |-> !gated_out_a_oe_o
		&& !select_out_a_oe_o && !term_out_a_oe_o && clk_en_out_o == 2'h0)
		else $error("outputs driven right after reset");
	chk_stop_float: assert property (s_clock_stopped |-> !gated_out_a_oe_o
		&& !gated_out_b_oe_o && !select_out_a_oe_o && !term_out_a_oe_o
		&& clk_en_out_a_oe_o && clk_en_out_b_oe_o && clk_en_out_o == 2'h0)
		else $error("stopped clock did not float outputs");
	chk_copy_a_gate: assert property (gated_out_a_oe_o |->
		$past(copy_a_en_i, 2) || $past(copy_a_en_i, 3))
		else $error("copy a driven while disabled");
	chk_copy_b_gate: assert property (select_out_b_oe_o |->
		$past(copy_b_en_i, 2) || $past(copy_b_en_i, 3))
		else $error("copy b select driven while disabled");
	chk_sel_copies: assert property (select_out_zero_copies_n_o == {2{select_out_quad_n_o[0]}}
		&& select_out_one_copies_n_o == {2{select_out_quad_n_o[1]}})
		else $error("select copies differ");
	chk_illegal_pulse: assert property (illegal_sel_o |=> !illegal_sel_o)
		else $error("illegal flag longer than one cycle");
	chk_stall_freeze: assert property (s_stalled |-> $stable(gated_out_addr_o)
		&& $stable(select_out_quad_n_o))
		else $error("outputs moved while stalled");
	chk_no_float_3t: assert property (s_pinned_drive |-> gated_out_a_oe_o)
		else $error("address floated in three-cycle timing");
endmodule // rcd_top_props

bind rcd_top rcd_top_props #(.FIFO_DEPTH(FIFO_DEPTH)) rcd_top_props_i (
	.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .ck_t_i(ck_t_i), .ck_c_i(ck_c_i),
	.copy_a_en_i(copy_a_en_i), .copy_b_en_i(copy_b_en_i), .drive_stall_i(drive_stall_i),
	.three_cycle_timing_i(three_cycle_timing_i), .illegal_sel_o(illegal_sel_o),
	.gated_out_addr_o(gated_out_addr_o), .gated_out_a_oe_o(gated_out_a_oe_o),
	.gated_out_b_oe_o(gated_out_b_oe_o), .select_out_quad_n_o(select_out_quad_n_o),
	.select_out_zero_copies_n_o(select_out_zero_copies_n_o),
	.select_out_one_copies_n_o(select_out_one_copies_n_o),
	.select_out_a_oe_o(select_out_a_oe_o), .select_out_b_oe_o(select_out_b_oe_o),
	.term_out_a_oe_o(term_out_a_oe_o), .clk_en_out_o(clk_en_out_o),
	.clk_en_out_a_oe_o(clk_en_out_a_oe_o), .clk_en_out_b_oe_o(clk_en_out_b_oe_o)
);

// ---- sim/tb_top.sv ----
`timescale 1ns/1ps
`define CMP(got, exp) begin comparisons++; if ((got) !== (exp)) begin failures++; \
	$display("unexpected at %0t: got %h expected %h", $time, got, exp); end end
module tb_top;
	localparam int DEPTH = 4; // small queue so filling it is quick
	logic sys_clk_i = 1'b0;
	logic arst_n_i = 1'b0;
	logic run = 1'b0;
	logic [31:0] word = 32'hb000_0000;
	logic copy_a = 1'b1, copy_b = 1'b1, t3 = 1'b0, stall = 1'b0, seen;
	logic [15:0] rnd = 16'h0021;
	logic ck_t, ck_c, ready, illegal, ga_oe, gb_oe, sa_oe, sb_oe, ta_oe, tb_oe, ca_oe, cb_oe;
	logic [31:0] pins, w;
	logic [15:0] addr, e_addr;
	logic [2:0] bank, cmd, e_bank, e_cmd;
	logic [1:0] term, cke, zc, oc, e_term, e_cke;
	logic [3:0] squad, e_sel;
	logic e_float, e_quad, e_t3;
	int failures = 0;
	int comparisons = 0;
	always #5 sys_clk_i = ~sys_clk_i;
	rcd_ctl_model rcd_ctl_model_i (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .run_i(run),
		.word_i(word), .ck_t_o(ck_t), .ck_c_o(ck_c), .pins_o(pins));
	rcd_top #(.FIFO_DEPTH(DEPTH)) rcd_top_i (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i),
		.ck_t_i(ck_t), .ck_c_i(ck_c), .addr_in_i(pins[15:0]), .bank_addr_in_i(pins[18:16]),
		.row_strobe_in_n_i(pins[21]), .col_strobe_in_n_i(pins[20]), .write_en_in_n_i(pins[19]),
		.term_in_i(pins[23:22]), .clk_en_in_i(pins[25:24]), .select_in_quad_n_i(pins[29:26]),
		.quad_select_enable_n_i(pins[31]), .addr_float_bit_i(pins[30]),
		.three_cycle_timing_i(t3), .copy_a_en_i(copy_a), .copy_b_en_i(copy_b),
		.drive_stall_i(stall), .cmd_ready_o(ready), .illegal_sel_o(illegal),
		.gated_out_addr_o(addr), .gated_out_bank_o(bank), .gated_out_cmd_n_o(cmd),
		.gated_out_a_oe_o(ga_oe), .gated_out_b_oe_o(gb_oe), .select_out_zero_copies_n_o(zc),
		.select_out_one_copies_n_o(oc), .select_out_quad_n_o(squad), .select_out_a_oe_o(sa_oe),
		.select_out_b_oe_o(sb_oe), .term_out_o(term), .term_out_a_oe_o(ta_oe),
		.term_out_b_oe_o(tb_oe), .clk_en_out_o(cke), .clk_en_out_a_oe_o(ca_oe),
		.clk_en_out_b_oe_o(cb_oe));
	// ---------------------------------------------------------------
	// expectation helpers
	// ---------------------------------------------------------------
	function automatic logic [15:0] lfsr_next(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	// word layout: quad_n, float bit, selects, cke, term, cmd, bank, addr
	function automatic logic [31:0] draw();
		logic [31:0] r;
		for (int i = 0; i < 32; i++) begin
			rnd = lfsr_next(rnd);
			r[i] = rnd[0];
		end
		return r;
	endfunction
	// 0 access, 1 control word, 2 deselect, 3 illegal
	function automatic logic [1:0] sel_kind(input logic quad_n, input logic [3:0] s);
		if (quad_n) return (s[1:0] == 2'h3) ? 2'h2 : (s[1:0] == 2'h0) ? 2'h1 : 2'h0;
		if (s == 4'hf) return 2'h2;
		if ($countones(s) == 1) return 2'h3;
		return (s[1:0] == 2'h0 || s[3:2] == 2'h0) ? 2'h1 : 2'h0;
	endfunction
	task automatic predict(input logic [31:0] v);
		logic [1:0] k;
		k = sel_kind(v[31], v[29:26]);
		if (k != 2'h3) e_quad = ~v[31];
		if (k == 2'h0 || k == 2'h2) {e_cke, e_term} = v[25:22];
		e_sel = (k == 2'h0) ? v[29:26] : (k == 2'h3) ? e_sel : 4'hf;
		if (k == 2'h0) {e_float, e_cmd, e_bank, e_addr} = {1'b0, v[21:0]};
		if (k == 2'h2) e_float = v[30] & ~e_t3;
	endtask
	task automatic check_reset();
		`CMP(ga_oe, 1'b0)
		`CMP(sb_oe, 1'b0)
		`CMP(ta_oe, 1'b0)
		`CMP(cke, 2'h0)
		`CMP(ca_oe, 1'b1)
	endtask
	task automatic check_outputs();
		`CMP(addr, e_addr)
		`CMP(bank, e_bank)
		`CMP(cmd, e_cmd)
		`CMP(term, e_term)
		`CMP(cke, e_cke)
		`CMP(zc, {2{e_sel[0]}})
		`CMP(oc, {2{e_sel[1]}})
		`CMP(squad[1:0], e_sel[1:0])
		if (e_quad) `CMP(squad, e_sel)
		`CMP(ga_oe, copy_a & ~e_float)
		`CMP(gb_oe, copy_b & ~e_float)
		`CMP(ta_oe, copy_a)
		`CMP(cb_oe, copy_b)
		`CMP({sa_oe, tb_oe}, {copy_a, copy_b})
	endtask
	// applies one word, lets it cross and settle, then compares
	task automatic send(input logic [31:0] v);
		@(posedge sys_clk_i);
		word <= v;
		predict(v);
		seen = 1'b0;
		repeat (12) @(negedge sys_clk_i) seen |= illegal;
		if (sel_kind(v[31], v[29:26]) == 2'h3) `CMP(seen, 1'b1)
		check_outputs();
	endtask
	task automatic tally_and_finish();
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial begin
		{e_addr, e_bank, e_cmd, e_term, e_cke, e_sel, e_float, e_quad, e_t3} = '0;
		for (int r = 0; r < 2; r++) begin
			repeat (16) @(posedge sys_clk_i);
			#1 check_reset();
			@(posedge sys_clk_i);
			arst_n_i <= 1'b1;
			run <= 1'b1;
			{e_addr, e_bank, e_cmd, e_term, e_cke, e_sel, e_float, e_quad, e_t3} = '0;
			send(32'hb000_0000);
			$display("test reset_and_first_word done");
			if (r == 1) tally_and_finish();
			// every select pattern in both modes, float bit alternating
			for (int i = 0; i < 32; i++) begin
				w = draw();
				send({i[4], i[0], i[3:0], w[25:0]});
			end
			$display("test select_patterns done");
			for (int i = 0; i < 40; i++) begin
				w = draw();
				if (sel_kind(w[31], w[29:26]) == 2'h3) w[29:26] = 4'hf;
				{copy_a, copy_b} <= w[1:0] ^ w[17:16];
				send(w);
			end
			$display("test random_words done");
			// far side stalls: queue fills and refuses, outputs freeze
			@(posedge sys_clk_i);
			{copy_a, copy_b, stall} <= 3'h7;
			w = draw();
			w[31:26] = 6'h37;
			word <= w;
			repeat (40) @(posedge sys_clk_i);
			#1 check_outputs();
			`CMP(ready, 1'b0)
			predict(w);
			@(posedge sys_clk_i) stall <= 1'b0;
			repeat (20) @(posedge sys_clk_i);
			#1 check_outputs();
			`CMP(ready, 1'b1)
			$display("test queue_fill_drain done");
			@(posedge sys_clk_i) run <= 1'b0;
			repeat (10) @(posedge sys_clk_i);
			#1 `CMP({ga_oe, sa_oe, ta_oe, ca_oe, cke}, 6'h04)
			@(posedge sys_clk_i) run <= 1'b1;
			repeat (12) @(posedge sys_clk_i);
			#1 check_outputs();
			$display("test clock_stop done");
			@(posedge sys_clk_i) t3 <= 1'b1;
			e_t3 = 1'b1;
			send(32'hfc00_0000);
			$display("test three_cycle_no_float done");
			@(posedge sys_clk_i);
			{arst_n_i, run, t3} <= 3'h0;
		end
	end
	// cut a hang short well beyond the expected run length
	initial begin
		repeat (6000) @(posedge sys_clk_i);
		failures++;
		tally_and_finish();
	end
endmodule // tb_top
